// ==== rtl/sys_clock_switch.v ====
// Purpose: Glitch-free system clock source switch with start-up and sleep control.
// Assumes: Both oscillators are slower than MCLK; the core events share MCLK.
// Notes: RST acts as the power-on reset.
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`include "sys_clock_switch_regs.vh"

module sys_clock_switch #(
	parameter POWER_UP_TIMER_CYCLES = `POWER_UP_TIMER_TIME_US * `MCLK_MHZ,
	parameter PLL_CYCLES = `PLL_TIME_US * `MCLK_MHZ,
	parameter OST_EDGES = `OST_EDGES,
	parameter SYNC_EDGES = `SYNC_EDGES
) (
	// Clock and power-on reset.
	input wire MCLK,
	input wire RST,
	// Register port.
	input wire [7:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	output reg [7:0] REG_RDATA,
	// Oscillator inputs, asynchronous to MCLK.
	input wire MAIN_OSC_IN,
	input wire SEC_OSC_IN,
	// Core events, synchronous to MCLK.
	input wire SLEEP_CMD,
	input wire WAKE_INT,
	input wire EXT_RST,
	input wire WDT_RST,
	input wire BROWNOUT_RST,
	// Clock and core control.
	output reg SYS_CLK_OUT,
	output reg CORE_FREEZE,
	output reg CORE_RESET_HOLD,
	output reg [1:0] QUARTER_PHASE,
	// Oscillator pins.
	output reg MAIN_OSC_RUN,
	output reg FEEDBACK_EN,
	output reg OSC_OUT_O,
	output reg OSC_OUT_OE,
	output reg PORT_A6_SEL
);

	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam ST_POWER_UP_TIMER = 7'b0000001;
	localparam ST_OST = 7'b0000010;
	localparam ST_PLL = 7'b0000100;
	localparam ST_RUN = 7'b0001000;
	localparam ST_WAITQ1 = 7'b0010000;
	localparam ST_SYNC = 7'b0100000;
	localparam ST_SLEEP = 7'b1000000;

	// Crystal modes need the start-up timer.
	function is_crystal;
		input [2:0] m;
		begin
			is_crystal = (m == `MODE_LP) || (m == `MODE_XT) ||
				(m == `MODE_HS) || (m == `MODE_HSPLL);
		end
	endfunction

	reg main_s1_ff, main_s2_ff, main_s3_ff;
	reg sec_s1_ff, sec_s2_ff, sec_s3_ff;
	reg sel_ff, src_ff, tgt_ff, sw_ff, boot_ff, sleep_pend_ff;
	reg [7:0] sec_ctl_ff;
	reg [7:0] cfg_ff;
	reg [6:0] state_ff;
	reg [6:0] nxt_state;
	reg [31:0] cnt_ff;
	reg [1:0] q_ff;
	wire main_rise;
	wire sec_rise;
	wire sel_rise;
	wire tgt_rise;
	wire [2:0] mode;
	wire switch_ok;
	wire any_rst;
	wire sleeping;

	// ----------------------------------------
	// Oscillator synchronisers
	// ----------------------------------------
	// Two stages before any logic; the third only feeds edge detection.
	always @(posedge MCLK)
	begin
		main_s1_ff <= MAIN_OSC_IN;
		main_s2_ff <= main_s1_ff;
		main_s3_ff <= main_s2_ff;
		sec_s1_ff <= SEC_OSC_IN;
		sec_s2_ff <= sec_s1_ff;
		sec_s3_ff <= sec_s2_ff;
	end

	// Rising edges of each source and of the active and target ones.
	assign main_rise = main_s2_ff & ~main_s3_ff;
	assign sec_rise = sec_s2_ff & ~sec_s3_ff;
	assign sel_rise = src_ff ? sec_rise : main_rise;
	assign tgt_rise = tgt_ff ? sec_rise : main_rise;
	assign mode = cfg_ff[`CFG_MODE_MSB:`CFG_MODE_LSB];
	// Fuse programmed to zero and secondary oscillator enabled.
	assign switch_ok = ~cfg_ff[`CFG_SWITCH_FUSE_BIT] & sec_ctl_ff[`SEC_OSC_EN_BIT];
	assign any_rst = EXT_RST | WDT_RST | BROWNOUT_RST;
	assign sleeping = (state_ff == ST_SLEEP);

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	// The select bit is forced clear whenever switching is not allowed, so a
	// later fuse or enable change cannot leave a stale request behind.
	always @(posedge MCLK)
	begin
		if (RST)
		begin
			sel_ff <= 1'b0;
			sec_ctl_ff <= `SEC_TMR_CTL_RESET;
			cfg_ff <= `DEV_CFG_RESET;
		end
		else
		begin
			if (REG_WR && REG_ADDR == `SEC_TMR_CTL_ADDR)
				sec_ctl_ff <= REG_WDATA;
			if (REG_WR && REG_ADDR == `DEV_CFG_ADDR)
				cfg_ff <= REG_WDATA;
			if (any_rst || !switch_ok)
				sel_ff <= 1'b0;
			else if (REG_WR && REG_ADDR == `OSC_CTL_ADDR)
				sel_ff <= REG_WDATA[`CLK_SEL_BIT];
		end
	end

	// ----------------------------------------
	// Register reads
	// ----------------------------------------
	// Data stand for one cycle after the strobe; unmapped addresses read zero.
	always @(posedge MCLK)
	begin
		if (RST || !REG_RD)
			REG_RDATA <= 8'h00;
		else
		begin
			case (REG_ADDR)
				`OSC_CTL_ADDR: REG_RDATA <= {7'h00, sel_ff};
				`SEC_TMR_CTL_ADDR: REG_RDATA <= sec_ctl_ff;
				`DEV_CFG_ADDR: REG_RDATA <= cfg_ff;
				`CLK_STATUS_ADDR: REG_RDATA <= {1'b0, sleeping, boot_ff, sw_ff,
					q_ff, tgt_ff, src_ff};
				default: REG_RDATA <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// Sequencer next state
	// ----------------------------------------
	always @*
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_POWER_UP_TIMER:
				if (cnt_ff >= POWER_UP_TIMER_CYCLES)
					nxt_state = is_crystal(mode) ? ST_OST : ST_RUN;
			ST_OST:
				if (cnt_ff >= OST_EDGES)
				begin
					if (mode == `MODE_HSPLL)
						nxt_state = ST_PLL;
					else
						nxt_state = sw_ff ? ST_SYNC : ST_RUN;
				end
			ST_PLL:
				if (cnt_ff >= PLL_CYCLES)
					nxt_state = sw_ff ? ST_SYNC : ST_RUN;
			ST_RUN:
				if (sel_ff != src_ff || sleep_pend_ff)
					nxt_state = ST_WAITQ1;
			ST_WAITQ1:
				if (q_ff == 2'b00)
				begin
					// The target is only latched on leaving this state, so the
					// select itself decides whether the start-up timer must run.
					if (sleep_pend_ff && sel_ff == src_ff)
						nxt_state = ST_SLEEP;
					else if (!sel_ff && is_crystal(mode))
						nxt_state = ST_OST;
					else
						nxt_state = ST_SYNC;
				end
			ST_SYNC:
				// Hand over only when both sources are low, so no runt appears.
				if (cnt_ff >= SYNC_EDGES && !main_s2_ff && !sec_s2_ff)
					nxt_state = ST_RUN;
			ST_SLEEP:
				if (WAKE_INT)
					nxt_state = is_crystal(mode) ? ST_OST : ST_RUN;
			default:
				nxt_state = ST_POWER_UP_TIMER;
		endcase
	end

	// ----------------------------------------
	// Sequencer registers
	// ----------------------------------------
	// Resets override everything; an external or watchdog reset also wakes
	// the part and, in crystal modes, goes through the start-up timer only from sleep.
	always @(posedge MCLK)
	begin
		if (RST)
		begin
			state_ff <= ST_POWER_UP_TIMER;
			cnt_ff <= 32'h00000000;
			src_ff <= 1'b0;
			tgt_ff <= 1'b0;
			sw_ff <= 1'b0;
			boot_ff <= 1'b1;
			sleep_pend_ff <= 1'b0;
			q_ff <= 2'b00;
		end
		else if (any_rst)
		begin
			cnt_ff <= 32'h00000000;
			tgt_ff <= 1'b0;
			sw_ff <= src_ff;
			boot_ff <= 1'b1;
			sleep_pend_ff <= 1'b0;
			q_ff <= 2'b00;
			if (BROWNOUT_RST && cfg_ff[`CFG_POWER_UP_TIMER_EN_BIT])
				state_ff <= ST_POWER_UP_TIMER;
			else if (is_crystal(mode) && (sleeping || BROWNOUT_RST))
				state_ff <= ST_OST;
			else if (src_ff)
				state_ff <= ST_SYNC;
			else
				state_ff <= ST_RUN;
		end
		else
		begin
			state_ff <= nxt_state;
			// Timers restart on every state change.
			if (nxt_state != state_ff)
				cnt_ff <= 32'h00000000;
			else if (state_ff == ST_POWER_UP_TIMER || state_ff == ST_PLL)
				cnt_ff <= cnt_ff + 32'h00000001;
			else if (state_ff == ST_OST && main_rise)
				cnt_ff <= cnt_ff + 32'h00000001;
			else if (state_ff == ST_SYNC && tgt_rise && cnt_ff < SYNC_EDGES)
				cnt_ff <= cnt_ff + 32'h00000001;
			// Sleep request is remembered until the sleep state is entered, after any pending switch.
			if (SLEEP_CMD && state_ff == ST_RUN)
				sleep_pend_ff <= 1'b1;
			else if (nxt_state == ST_SLEEP)
				sleep_pend_ff <= 1'b0;
			// Freeze point: capture the target of the switch.
			if (state_ff == ST_WAITQ1 && nxt_state != ST_WAITQ1 &&
				nxt_state != ST_SLEEP)
			begin
				tgt_ff <= sel_ff;
				sw_ff <= 1'b1;
			end
			// Mux moves only at the end of synchronisation.
			if (state_ff == ST_SYNC && nxt_state == ST_RUN)
				src_ff <= tgt_ff;
			if (nxt_state == ST_RUN)
			begin
				sw_ff <= 1'b0;
				boot_ff <= 1'b0;
			end
			// Quarter phases advance on the active source only while running.
			if ((state_ff == ST_RUN || state_ff == ST_WAITQ1) && sel_rise &&
				nxt_state == state_ff)
				q_ff <= q_ff + 2'b01;
		end
	end

	// ----------------------------------------
	// Clock and core outputs
	// ----------------------------------------
	// The output clock follows the active source only while running, so a
	// freeze or sleep holds it low with no partial pulse.
	always @(posedge MCLK)
	begin
		if (RST)
		begin
			SYS_CLK_OUT <= 1'b0;
			CORE_FREEZE <= 1'b1;
			CORE_RESET_HOLD <= 1'b1;
			QUARTER_PHASE <= 2'b00;
		end
		else
		begin
			if (state_ff == ST_RUN || state_ff == ST_WAITQ1)
				SYS_CLK_OUT <= src_ff ? sec_s2_ff : main_s2_ff;
			else
				SYS_CLK_OUT <= 1'b0;
			CORE_FREEZE <= (state_ff != ST_RUN && state_ff != ST_WAITQ1);
			CORE_RESET_HOLD <= boot_ff && (state_ff != ST_RUN);
			QUARTER_PHASE <= q_ff;
		end
	end

	// ----------------------------------------
	// Oscillator pin control
	// ----------------------------------------
	// In RC and EC modes the second pin carries the instruction clock, which
	// is the top quarter bit; the I/O variants hand the pin to the port.
	always @(posedge MCLK)
	begin
		if (RST)
		begin
			MAIN_OSC_RUN <= 1'b1;
			FEEDBACK_EN <= 1'b0;
			OSC_OUT_O <= 1'b0;
			OSC_OUT_OE <= 1'b0;
			PORT_A6_SEL <= 1'b0;
		end
		else
		begin
			MAIN_OSC_RUN <= ~sleeping;
			FEEDBACK_EN <= is_crystal(mode) & ~sleeping;
			PORT_A6_SEL <= (mode == `MODE_RESISTOR_CAPACITOR_IO_MODE) || (mode == `MODE_EXTERNAL_CLOCK_IO_PIN_MODE);
			OSC_OUT_OE <= (mode == `MODE_RC) || (mode == `MODE_EC);
			OSC_OUT_O <= ~sleeping & q_ff[1];
		end
	end

endmodule // sys_clock_switch

// ==== rtl/sys_clock_switch_regs.vh ====
// Purpose: Register map, field positions and timing figures of the clock switch.
// Assumes: One 8-bit register per address on the plain register port.
// Notes: Definitions only.
`ifndef SYS_CLOCK_SWITCH_REGS_VH
`define SYS_CLOCK_SWITCH_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OSC_CTL_ADDR 8'h00
`define SEC_TMR_CTL_ADDR 8'h01
`define DEV_CFG_ADDR 8'h02
`define CLK_STATUS_ADDR 8'h03

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CLK_SEL_BIT 0
`define SEC_OSC_EN_BIT 0
`define CFG_MODE_LSB 0
`define CFG_MODE_MSB 2
`define CFG_SWITCH_FUSE_BIT 3
`define CFG_POWER_UP_TIMER_EN_BIT 4
`define DEV_CFG_RESET 8'h0A
`define SEC_TMR_CTL_RESET 8'h00

// ----------------------------------------
// Main oscillator modes
// ----------------------------------------
`define MODE_LP 3'h0
`define MODE_XT 3'h1
`define MODE_HS 3'h2
`define MODE_HSPLL 3'h3
`define MODE_RC 3'h4
`define MODE_RESISTOR_CAPACITOR_IO_MODE 3'h5
`define MODE_EC 3'h6
`define MODE_EXTERNAL_CLOCK_IO_PIN_MODE 3'h7

// ----------------------------------------
// Timing figures
// ----------------------------------------
`define MCLK_MHZ 40
`define SYNC_EDGES 8
`define OST_EDGES 1024
`define POWER_UP_TIMER_TIME_US 72000
`define PLL_TIME_US 2000

`endif

// ==== bench/osc_sources.sv ====
// Purpose: Model of the main and secondary oscillators.
// Assumes: Both run well below the system clock rate.
// Notes: The main oscillator stops while its run enable is low.
module osc_sources #(
	parameter int MH = 50,
	parameter int SH = 400
) (
	input wire logic run,
	output logic main_osc,
	output logic sec_osc
);
	timeunit 1ns;
	timeprecision 1ps;

	// The watch crystal runs all the time, as the switch expects.
	initial
	begin
		sec_osc = 1'h0;
		forever #(SH) sec_osc = ~sec_osc;
	end

	// A stopped crystal rests low, so no stray edge reaches the counters.
	initial
	begin
		main_osc = 1'h0;
		forever #(MH) main_osc = run ? ~main_osc : 1'h0;
	end
endmodule // osc_sources

// ==== bench/sys_clock_switch_properties.sv ====
// Purpose: Concurrent checks on the clock switch ports.
// Assumes: One MCLK domain with synchronous active-high RST.
// Notes: Bound to every instance of the design.
module clk_switch_checker (
	input wire MCLK, RST, REG_RD, EXT_RST, WDT_RST, BROWNOUT_RST,
	input wire [7:0] REG_ADDR,
	input wire [7:0] REG_RDATA,
	input wire SYS_CLK_OUT, CORE_FREEZE, CORE_RESET_HOLD, MAIN_OSC_RUN,
	input wire FEEDBACK_EN, OSC_OUT_O, OSC_OUT_OE, PORT_A6_SEL,
	input wire [1:0] QUARTER_PHASE
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);

	chk_ctl_upper_zero: assert property (REG_RD && REG_ADDR == 8'h00 |=> REG_RDATA[7:1] == 7'h00)
		else $error("control upper bits read nonzero");
	chk_reset_clears_sel: assert property ((EXT_RST || WDT_RST || BROWNOUT_RST) ##[1:3]
		(REG_RD && REG_ADDR == 8'h00) |=> !REG_RDATA[0]) else $error("select survived reset");
	chk_freeze_clk_low: assert property (CORE_FREEZE && $past(CORE_FREEZE) |-> !SYS_CLK_OUT)
		else $error("clock pulse while frozen");
	chk_freeze_min_sync: assert property ($rose(CORE_FREEZE) && MAIN_OSC_RUN &&
		!CORE_RESET_HOLD |-> CORE_FREEZE[*8]) else $error("freeze shorter than sync count");
	chk_hold_freezes: assert property (CORE_RESET_HOLD |-> CORE_FREEZE)
		else $error("core runs during reset hold");
	chk_power_up_timer_hold: assert property ($fell(RST) |-> CORE_RESET_HOLD[*8])
		else $error("power-up hold too short");
	chk_sleep_core_q1: assert property (!MAIN_OSC_RUN |-> QUARTER_PHASE == 2'h0 && CORE_FREEZE)
		else $error("sleep not held at first quarter");
	chk_sleep_pins: assert property (!MAIN_OSC_RUN |-> !FEEDBACK_EN && !OSC_OUT_O)
		else $error("oscillator pins active in sleep");
	chk_io_pin_mode: assert property (PORT_A6_SEL |-> !OSC_OUT_OE && !FEEDBACK_EN)
		else $error("port pin also driven by oscillator");
endmodule // clk_switch_checker

bind sys_clock_switch clk_switch_checker chk_u (.*);

// ==== bench/tb_sys_clock_switch.sv ====
// Purpose: Self-checking bench for the clock switch.
// Assumes: The oscillator model runs slower than MCLK.
// Notes: Long timer counts are shortened by parameter.
`include "sys_clock_switch_regs.vh"
module tb_sys_clock_switch;
	timeunit 1ns;
	timeprecision 1ps;
	logic MCLK, RST, REG_WR, REG_RD, SLEEP_CMD, WAKE_INT, EXT_RST, WDT_RST, BROWNOUT_RST;
	logic [7:0] REG_ADDR, REG_WDATA;
	wire [7:0] REG_RDATA;
	wire [1:0] QUARTER_PHASE;
	wire MAIN_OSC_IN, SEC_OSC_IN, SYS_CLK_OUT, CORE_FREEZE, CORE_RESET_HOLD;
	wire MAIN_OSC_RUN, FEEDBACK_EN, OSC_OUT_O, OSC_OUT_OE, PORT_A6_SEL;
	int fails = 0;
	int samples_checked = 0;
	int n;
	logic [2:0] md[4] = '{`MODE_HS, `MODE_HSPLL, `MODE_RC, `MODE_EXTERNAL_CLOCK_IO_PIN_MODE};
	int lo[4] = '{92, 112, 28, 28};
	int hi[4] = '{111, 140, 50, 50};
	logic [2:0] sm[3] = '{`MODE_RC, `MODE_RESISTOR_CAPACITOR_IO_MODE, `MODE_HS};
	logic [7:0] se[3] = '{8'h08, 8'h04, 8'h00};

	sys_clock_switch #(.POWER_UP_TIMER_CYCLES(50), .PLL_CYCLES(20), .OST_EDGES(16), .SYNC_EDGES(8)) dut_u (.*);
	osc_sources osc_u (.run(MAIN_OSC_RUN), .main_osc(MAIN_OSC_IN), .sec_osc(SEC_OSC_IN));

	// Free-running 40 MHz system clock.
	initial
	begin
		MCLK = 1'h0;
		forever #12.5 MCLK = ~MCLK;
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge MCLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'h1;
		@(posedge MCLK);
		REG_WR <= 1'h0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample there.
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge MCLK);
		REG_ADDR <= a;
		REG_RD <= 1'h1;
		@(posedge MCLK);
		REG_RD <= 1'h0;
		#1 check(REG_RDATA, exp);
	endtask

	// Pulses one core event for a cycle: 0 sleep, 1 wake, 2 ext, 3 watchdog, 4 brown-out.
	task automatic pulse(input int k);
		@(posedge MCLK);
		{SLEEP_CMD, WAKE_INT, EXT_RST, WDT_RST, BROWNOUT_RST} <= 5'h10 >> k;
		@(posedge MCLK);
		{SLEEP_CMD, WAKE_INT, EXT_RST, WDT_RST, BROWNOUT_RST} <= 5'h00;
	endtask

	// Waits for freeze or reset hold to reach a level, counting cycles into n.
	task automatic await(input bit h, input logic lvl);
		n = 0;
		while ((h ? CORE_RESET_HOLD : CORE_FREEZE) !== lvl)
		begin
			@(posedge MCLK);
			#1 n++;
			if (n > 9000)
			begin
				fails++;
				end_sim();
			end
		end
	endtask

	initial
	begin
		{RST, REG_WR, REG_RD, SLEEP_CMD, WAKE_INT, EXT_RST, WDT_RST, BROWNOUT_RST} = 8'h80;
		REG_ADDR = 8'h00;
		REG_WDATA = 8'h00;
		repeat (16) @(posedge MCLK);
		RST <= 1'h0;
		await(0, 0);
		// Running from the main source, the system clock is high half of the time.
		n = 0;
		repeat (8) @(posedge MCLK) #1 n += SYS_CLK_OUT;
		check(n[7:0], 8'h04);
		rd(8'h00, 8'h00);
		rd(8'h02, `DEV_CFG_RESET);
		rd(8'hFF, 8'h00);
		wr(8'h01, 8'h01);
		wr(8'h00, 8'hFF);
		rd(8'h00, 8'h00);
		wr(8'h01, 8'h00);
		wr(8'h02, 8'h02);
		wr(8'h00, 8'h01);
		rd(8'h00, 8'h00);
		// Four main modes, HS, HSPLL, RC and EC I/O: out to the watch crystal and back, timing both freezes.
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h01, 8'h01);
			wr(8'h02, {5'h00, md[i]});
			wr(8'h00, 8'hFF);
			rd(8'h00, 8'h01);
			await(0, 1);
			await(0, 0);
			check(n >= 224 && n <= 300, 1);
			wr(8'h00, 8'h00);
			await(0, 1);
			await(0, 0);
			check(n >= lo[i] && n <= hi[i], 1);
		end
		wr(8'h00, 8'h01);
		await(0, 1);
		await(0, 0);
		wr(8'h01, 8'h00);
		rd(8'h00, 8'h00);
		// The forced clear starts a switch back to main; let it finish.
		await(0, 1);
		await(0, 0);
		wr(8'h01, 8'h01);
		// Every reset kind taken while running from the watch crystal.
		for (int k = 2; k < 5; k++)
		begin
			wr(8'h00, 8'h01);
			await(0, 1);
			await(0, 0);
			pulse(k);
			rd(8'h00, 8'h00);
			await(0, 0);
		end
		// Sleep in three modes, each left by a different wake source.
		for (int i = 0; i < 3; i++)
		begin
			wr(8'h02, {5'h00, sm[i]});
			pulse(0);
			await(0, 1);
			repeat (3) @(posedge MCLK);
			#1 check({MAIN_OSC_RUN, FEEDBACK_EN, OSC_OUT_O, OSC_OUT_OE, PORT_A6_SEL, QUARTER_PHASE}, se[i]);
			pulse(i + 1);
			await(0, 0);
			check(MAIN_OSC_RUN, 1);
		end
		check(FEEDBACK_EN, 1);
		wr(8'h02, 8'h14);
		pulse(4);
		await(1, 1);
		await(1, 0);
		check(n >= 48 && n <= 60, 1);
		end_sim();
	end
endmodule // tb_sys_clock_switch
